//--- common/mpt_params.svh
// register offsets, field positions, reset values and timing figures of the modulo timer
`ifndef MPT_PARAMS_SVH
`define MPT_PARAMS_SVH

`define MPT_OFF_STATUS_CONTROL 8'h4B
`define MPT_OFF_COUNT_HIGH     8'h4C
`define MPT_OFF_COUNT_LOW      8'h4D
`define MPT_OFF_MODULO_HIGH    8'h4E
`define MPT_OFF_MODULO_LOW     8'h4F

`define MPT_BIT_OVF            7
`define MPT_BIT_IRQ_EN         6
`define MPT_BIT_HALT           5
`define MPT_BIT_CLEAR          4
`define MPT_PS_MSB             2
`define MPT_PS_LSB             0

`define MPT_RST_PS             3'h0
`define MPT_RST_HALT           1'h1
`define MPT_RST_MODULO         16'hFFFF
`define MPT_RST_COUNT          16'h0000

`define MPT_PS_MAX_CODE        3'h6
`define MPT_PRESCALE_W         6

`endif

//--- common/mpt_pkg.sv
// types shared by the modulo timer files
package mpt_pkg;
  typedef enum logic [1:0] {
    MPT_ARM_IDLE,
    MPT_ARM_READY
  } mpt_arm_type;
endpackage

//--- rtl/mpt_prescaler.sv
// free-running bus clock divider that emits one-cycle ticks at the selected rate
`timescale 1ns/1ps
`include "mpt_params.svh"
module mpt_prescaler #(
  parameter int WIDTH = `MPT_PRESCALE_W
) (
  input  wire logic       clk,      // bus clock
  input  wire logic       rst,      // synchronous reset, active high
  input  wire logic       clear,    // restart the divider from zero
  input  wire logic [2:0] select,   // prescale select code
  output logic            tick      // one-cycle count enable
);
  logic [WIDTH-1:0] div_q;
  logic [2:0]       sel_eff;

  // codes 110 and 111 both give divide by 64
  assign sel_eff = (select > `MPT_PS_MAX_CODE) ? `MPT_PS_MAX_CODE : select;

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // tick when the low sel_eff bits are all one: period 2**sel_eff cycles
  always_comb begin
    tick = 1'b1;
    for (int i = 0; i < WIDTH; i++) begin
      if (i < int'(sel_eff) && !div_q[i]) begin
        tick = 1'b0;
      end
    end
  end

  property p_tick_div1;
    @(posedge clk) disable iff (rst)
      (select == 3'h0) |-> tick;
  endproperty
  a_tick_div1: assert property (p_tick_div1) else $error("divide by one must tick every cycle");
endmodule

//--- rtl/mpt_timer.sv
// modulo periodic timer with classic wishbone register access
//
// Function
// - 16-bit up-counter, free-run or modulo
// - counter reads never disturb counting
// - prescale divides by 1..64, 11x is 64
// - tick after match sets flag and returns zero
// - flag cleared by read then zero write
// - new overflow voids pending zero write
// - irq when flag and enable both set
// - halt holds counter; reset sets halt
// - clear bit resets counter and prescaler
// - halt plus clear stops at zero
// - high read latches low byte
// - reset and clear zero the counter
// - modulo high write masks flag until low
// - reset sets modulo to all ones
// - wait mode keeps counting, irq wakes
// - stop mode freezes counting, keeps state
// - break freezes the counter
// - break without enable protects flag clears
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "mpt_params.svh"
module mpt_timer
  import mpt_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        clk,                // bus clock, 250 MHz
  input  wire logic        rst,                // synchronous reset, active high
  input  wire logic        wb_cyc_i,           // wishbone cycle
  input  wire logic        wb_stb_i,           // wishbone strobe
  input  wire logic        wb_we_i,            // wishbone write enable
  input  wire logic [7:0]  wb_adr_i,           // wishbone byte address
  input  wire logic [7:0]  wb_dat_i,           // wishbone write data
  input  wire logic        wb_sel_i,           // wishbone byte select
  output logic      [7:0]  wb_dat_o,           // wishbone read data
  output logic             wb_ack_o,           // wishbone acknowledge
  input  wire logic        wait_mode,          // system wait state
  input  wire logic        stop_mode,          // system stop state
  input  wire logic        break_state,        // system break state
  input  wire logic        break_clear_enable, // allow flag clears in break
  output logic             overflow_irq        // overflow interrupt request
);
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] modulo_q;
  logic [7:0]       low_latch_q;
  logic             latched_q;
  logic             overflow_flag_q;
  logic             overflow_irq_enable_q;
  logic             counter_halt_q;
  logic [2:0]       prescale_select_q;
  logic             mod_inhibit_q;
  logic             clear_pulse_q;
  mpt_arm_type      arm_q;
  logic             wait_s1_q, wait_s2_q;
  logic             stop_s1_q, stop_s2_q;
  logic             brk_s1_q, brk_s2_q;
  logic             bce_s1_q, bce_s2_q;
  logic             tick;
  logic             access, wr, rd;
  logic             advance;
  logic             match;
  logic             overflow_evt;
  logic [7:0]       rd_data;

  // level inputs from system logic pass two flops
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_s1_q <= 1'b0;
      wait_s2_q <= 1'b0;
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
      brk_s1_q  <= 1'b0;
      brk_s2_q  <= 1'b0;
      bce_s1_q  <= 1'b0;
      bce_s2_q  <= 1'b0;
    end else begin
      wait_s1_q <= wait_mode;
      wait_s2_q <= wait_s1_q;
      stop_s1_q <= stop_mode;
      stop_s2_q <= stop_s1_q;
      brk_s1_q  <= break_state;
      brk_s2_q  <= brk_s1_q;
      bce_s1_q  <= break_clear_enable;
      bce_s2_q  <= bce_s1_q;
    end
  end

  // ack on the cycle after the request, dropped the next cycle
  // registers are not reachable in wait mode; the bus still gets an answer
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o && !wait_s2_q;
  assign wr     = access && wb_we_i && wb_sel_i;
  assign rd     = access && !wb_we_i;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_comb begin
    rd_data = 8'h00;
    if (hit(wb_adr_i, `MPT_OFF_STATUS_CONTROL)) begin
      // clear bit and bit 3 read as zero
      rd_data = {overflow_flag_q, overflow_irq_enable_q, counter_halt_q, 2'b00, prescale_select_q};
    end else if (hit(wb_adr_i, `MPT_OFF_COUNT_HIGH)) begin
      rd_data = count_q[15:8];
    end else if (hit(wb_adr_i, `MPT_OFF_COUNT_LOW)) begin
      rd_data = latched_q ? low_latch_q : count_q[7:0];
    end else if (hit(wb_adr_i, `MPT_OFF_MODULO_HIGH)) begin
      rd_data = modulo_q[15:8];
    end else if (hit(wb_adr_i, `MPT_OFF_MODULO_LOW)) begin
      rd_data = modulo_q[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= 8'h00;
    end else if (rd) begin
      wb_dat_o <= rd_data;
    end
  end

  // control fields
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_irq_enable_q <= 1'b0;
      counter_halt_q        <= `MPT_RST_HALT;
      prescale_select_q     <= `MPT_RST_PS;
    end else if (wr && hit(wb_adr_i, `MPT_OFF_STATUS_CONTROL)) begin
      overflow_irq_enable_q <= wb_dat_i[`MPT_BIT_IRQ_EN];
      counter_halt_q        <= wb_dat_i[`MPT_BIT_HALT];
      prescale_select_q     <= wb_dat_i[`MPT_PS_MSB:`MPT_PS_LSB];
    end
  end

  // write-only clear bit: one-cycle pulse, never stored for readback
  always_ff @(posedge clk) begin
    if (rst) begin
      clear_pulse_q <= 1'b0;
    end else begin
      clear_pulse_q <= wr && hit(wb_adr_i, `MPT_OFF_STATUS_CONTROL) && wb_dat_i[`MPT_BIT_CLEAR];
    end
  end

  mpt_prescaler #(
    .WIDTH (`MPT_PRESCALE_W)
  ) u_prescaler (
    .clk    (clk),
    .rst    (rst),
    .clear  (clear_pulse_q),
    .select (prescale_select_q),
    .tick   (tick)
  );

  // stop and break freeze the count; wait does not
  assign advance = tick && !counter_halt_q && !stop_s2_q && !brk_s2_q && !clear_pulse_q;
  assign match   = (count_q == modulo_q);
  assign overflow_evt = advance && match && !mod_inhibit_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= `MPT_RST_COUNT;
    end else if (clear_pulse_q) begin
      count_q <= `MPT_RST_COUNT;
    end else if (advance) begin
      // rollover at the modulo value; all ones gives free-running
      count_q <= match ? `MPT_RST_COUNT : count_q + 1'b1;
    end
  end

  // counter low byte latch
  always_ff @(posedge clk) begin
    if (rst) begin
      latched_q   <= 1'b0;
      low_latch_q <= 8'h00;
    end else if (rd && hit(wb_adr_i, `MPT_OFF_COUNT_HIGH) && !latched_q) begin
      latched_q   <= 1'b1;
      low_latch_q <= count_q[7:0];
    end else if (rd && hit(wb_adr_i, `MPT_OFF_COUNT_LOW)) begin
      latched_q   <= 1'b0;
    end
  end

  // modulo: high byte takes effect at once; the flag stays masked until the low byte write
  always_ff @(posedge clk) begin
    if (rst) begin
      modulo_q          <= `MPT_RST_MODULO;
      mod_inhibit_q     <= 1'b0;
    end else if (wr && hit(wb_adr_i, `MPT_OFF_MODULO_HIGH)) begin
      modulo_q[15:8]    <= wb_dat_i;
      mod_inhibit_q     <= 1'b1;
    end else if (wr && hit(wb_adr_i, `MPT_OFF_MODULO_LOW)) begin
      modulo_q[7:0]     <= wb_dat_i;
      mod_inhibit_q     <= 1'b0;
    end
  end

  // two-step clear: arming read, then zero write; new overflow disarms
  always_ff @(posedge clk) begin
    if (rst) begin
      arm_q <= MPT_ARM_IDLE;
    end else begin
      unique case (arm_q)
        MPT_ARM_IDLE: begin
          if (rd && hit(wb_adr_i, `MPT_OFF_STATUS_CONTROL) && overflow_flag_q && !overflow_evt
              && (!brk_s2_q || bce_s2_q)) begin
            arm_q <= MPT_ARM_READY;
          end
        end
        MPT_ARM_READY: begin
          if (overflow_evt) begin
            arm_q <= MPT_ARM_IDLE;
          end else if (wr && hit(wb_adr_i, `MPT_OFF_STATUS_CONTROL) && (!brk_s2_q || bce_s2_q)) begin
            arm_q <= MPT_ARM_IDLE;
          end
        end
        default: arm_q <= MPT_ARM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_flag_q <= 1'b0;
    end else if (overflow_evt) begin
      overflow_flag_q <= 1'b1;
    end else if (arm_q == MPT_ARM_READY && wr && hit(wb_adr_i, `MPT_OFF_STATUS_CONTROL)
                 && !wb_dat_i[`MPT_BIT_OVF] && (!brk_s2_q || bce_s2_q)) begin
      overflow_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= overflow_flag_q && overflow_irq_enable_q;
    end
  end

  property p_irq_follows;
    @(posedge clk) disable iff (rst)
      (overflow_flag_q && overflow_irq_enable_q) |=> overflow_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq missing with flag and enable");

  property p_halt_holds;
    @(posedge clk) disable iff (rst)
      (counter_halt_q && !clear_pulse_q) |=> $stable(count_q);
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("counter moved while halted");

  property p_clear_zero;
    @(posedge clk) disable iff (rst)
      clear_pulse_q |=> (count_q == 16'h0000);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero the counter");

  property p_rollover;
    @(posedge clk) disable iff (rst)
      (advance && match && !clear_pulse_q) |=> (count_q == 16'h0000);
  endproperty
  a_rollover: assert property (p_rollover) else $error("no rollover at modulo match");

  property p_flag_set;
    @(posedge clk) disable iff (rst)
      overflow_evt |=> overflow_flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow did not set flag");

  property p_inhibit;
    @(posedge clk) disable iff (rst)
      (mod_inhibit_q && !overflow_flag_q) |=> !$rose(overflow_flag_q);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("flag set during modulo update");

  property p_break_freeze;
    @(posedge clk) disable iff (rst)
      (brk_s2_q && !clear_pulse_q) |=> $stable(count_q);
  endproperty
  a_break_freeze: assert property (p_break_freeze) else $error("counter moved in break");

  property p_break_protect;
    @(posedge clk) disable iff (rst)
      (brk_s2_q && !bce_s2_q && overflow_flag_q) |=> overflow_flag_q;
  endproperty
  a_break_protect: assert property (p_break_protect) else $error("flag cleared in protected break");

  property p_stop_freeze;
    @(posedge clk) disable iff (rst)
      (stop_s2_q && !clear_pulse_q) |=> $stable(count_q);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("counter moved in stop");

  property p_clear_needs_arm;
    @(posedge clk) disable iff (rst)
      $fell(overflow_flag_q) |-> $past(arm_q) == MPT_ARM_READY;
  endproperty
  a_clear_needs_arm: assert property (p_clear_needs_arm) else $error("flag cleared without arming read");

  property p_wait_runs;
    @(posedge clk) disable iff (rst)
      (wait_s2_q && advance && !match) |=> (count_q == $past(count_q) + 16'h0001);
  endproperty
  a_wait_runs: assert property (p_wait_runs) else $error("counter stalled in wait mode");
endmodule

//--- test/modulo_periodic_timer_bench.sv
// self-checking bench for the modulo periodic timer
`timescale 1ns/1ps
module modulo_periodic_timer_bench;
  logic        clk = 0;
  logic        rst = 1;
  logic        cyc = 0;
  logic        stb = 0;
  logic        we = 0;
  logic        sel = 0;
  logic [7:0]  adr = 8'h00;
  logic [7:0]  wdat = 8'h00;
  logic [7:0]  rdat;
  logic        ack;
  logic        irq;
  logic        wmode = 0;
  logic        smode = 0;
  logic        brk = 0;
  logic        bce = 0;
  logic [7:0]  rd;
  logic [7:0]  hi;
  logic [15:0] v;
  logic [15:0] v1;
  int          err_total = 0;
  int          checks = 0;
  int          seed = 87;
  int          now = 0;
  int          t0 = 0;
  int          ts = 0;
  int          div = 1;
  int          n = 0;

  always #2 clk = ~clk;
  always @(posedge clk) now <= now + 1;

  mpt_timer u_mpt_timer (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wait_mode(wmode), .stop_mode(smode),
    .break_state(brk), .break_clear_enable(bce), .overflow_irq(irq)
  );

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle; request held until the rising edge that samples ack high, data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 1;
    @(posedge clk);
    while (ack !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    rd = rdat;
    if (k >= 50) err_total++;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk);
  endtask

  // high, high again after a gap, then low: the low byte must be the one held at the first read
  task automatic cnt(input int gap, output logic [15:0] val);
    bus(0, 8'h4C, 8'h00);
    hi = rd;
    repeat (gap) @(posedge clk);
    bus(0, 8'h4C, 8'h00);
    bus(0, 8'h4D, 8'h00);
    val = {hi, rd};
  endtask

  // read latency makes the exact tick uncertain, so a small window is allowed
  function automatic logic near(input logic [15:0] val, input int e);
    return (int'(val) >= e - 3) && (int'(val) <= e + 3);
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    bus(0, 8'h4B, 8'h00);
    check("ctrl reset", rd, 8'h20);
    bus(0, 8'h4E, 8'h00);
    check("modh reset", rd, 8'hFF);
    bus(0, 8'h4F, 8'h00);
    check("modl reset", rd, 8'hFF);
    repeat (20) @(posedge clk);
    bus(1, 8'h4C, 8'($random(seed)));
    bus(1, 8'h50, 8'($random(seed)));
    bus(0, 8'h50, 8'h00);
    check("unmapped", rd, 8'h00);
    cnt(0, v);
    check("halted count", v, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      div = 1 << (c > 6 ? 6 : c);
      bus(1, 8'h4B, 8'(8'h10 | c));
      t0 = now;
      repeat (6 * div) @(posedge clk);
      ts = now;
      cnt(40, v);
      check("tick rate", near(v, (ts - t0) / div), 1);
    end
    bus(0, 8'h4B, 8'h00);
    check("clear reads 0", rd, 8'h07);
    bus(1, 8'h4B, 8'h30);
    repeat (30) @(posedge clk);
    cnt(0, v);
    check("halt and clear", v, 16'h0000);
    bus(1, 8'h4E, 8'h00);
    bus(1, 8'h4F, 8'h03);
    bus(1, 8'h4B, 8'h40);
    for (n = 0; n < 50 && irq !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    check("irq", irq, 1);
    cnt(0, v);
    check("modulo wrap", v <= 16'h0003, 1);
    bus(0, 8'h4B, 8'h00);
    repeat (8) @(posedge clk);
    bus(1, 8'h4B, 8'h40);
    bus(0, 8'h4B, 8'h00);
    check("kept by overflow", rd[7], 1);
    bus(1, 8'h4B, 8'hE0);
    bus(0, 8'h4B, 8'h00);
    bus(1, 8'h4B, 8'h60);
    bus(0, 8'h4B, 8'h00);
    check("flag cleared", rd, 8'h60);
    check("irq dropped", irq, 0);
    bus(1, 8'h4B, 8'hE0);
    bus(0, 8'h4B, 8'h00);
    check("one write", rd, 8'h60);
    bus(1, 8'h4E, 8'h00);
    bus(1, 8'h4B, 8'h40);
    repeat (40) @(posedge clk);
    bus(0, 8'h4B, 8'h00);
    check("inhibited", rd, 8'h40);
    bus(1, 8'h4F, 8'h03);
    repeat (20) @(posedge clk);
    bus(0, 8'h4B, 8'h00);
    check("released", rd[7], 1);
    for (int b = 0; b < 2; b++) begin
      bus(1, 8'h4B, 8'h40);
      repeat (20) @(posedge clk);
      bus(1, 8'h4B, 8'hE0);
      bus(0, 8'h4B, 8'h00);
      brk <= 1;
      bce <= 1'(b);
      repeat (4) @(posedge clk);
      bus(1, 8'h4B, 8'h60);
      bus(0, 8'h4B, 8'h00);
      check("clear in break", rd[7], 1'(!b));
      brk <= 0;
      repeat (4) @(posedge clk);
      bus(1, 8'h4B, 8'h60);
      bus(0, 8'h4B, 8'h00);
      check("after break", rd, 8'h60);
    end
    wmode <= 1;
    repeat (4) @(posedge clk);
    bus(1, 8'h4B, 8'h00);
    wmode <= 0;
    repeat (4) @(posedge clk);
    bus(0, 8'h4B, 8'h00);
    check("wait ignores", rd, 8'h60);
    bus(1, 8'h4E, 8'hFF);
    bus(1, 8'h4F, 8'hFF);
    bus(1, 8'h4B, 8'h00);
    for (int m = 0; m < 2; m++) begin
      smode <= (m == 0);
      brk <= (m == 1);
      repeat (4) @(posedge clk);
      cnt(0, v1);
      repeat (50) @(posedge clk);
      cnt(0, v);
      check("frozen", v, v1);
      smode <= 0;
      brk <= 0;
      repeat (60) @(posedge clk);
      cnt(0, v);
      check("resumed", v > v1 + 16'd40, 1);
    end
    cnt(0, v1);
    wmode <= 1;
    repeat (50) @(posedge clk);
    wmode <= 0;
    repeat (4) @(posedge clk);
    cnt(0, v);
    check("wait counts", v > v1 + 16'd40, 1);
    final_report();
  end
endmodule
